// >>> core/usbec_pkg.sv
// usbec_pkg: offsets, field positions, reset values and carrier types
// of the usb error-enable / status / control block.
// assumes a word-indexed avalon-mm slave port, byte address = 4 * index.
`default_nettype none
package usbec_pkg;

    // word indices of the registers
    localparam logic [2:0] IDX_ERR_FLAGS  = 3'h0;
    localparam logic [2:0] IDX_ERR_ENABLE = 3'h1;
    localparam logic [2:0] IDX_STATUS     = 3'h2;
    localparam logic [2:0] IDX_CONTROL    = 3'h3;
    localparam logic [2:0] IDX_IRQ_ENABLE = 3'h4;
    localparam logic [2:0] IDX_IRQ_FLAGS  = 3'h5;

    // control bit positions
    localparam int unsigned CTL_J_BIT      = 7;
    localparam int unsigned CTL_SE0_BIT    = 6;
    localparam int unsigned CTL_PACKET_DISABLE_BIT = 5;
    localparam int unsigned CTL_BUSRST_BIT = 4;
    localparam int unsigned CTL_HOST_ENABLE_BIT = 3;
    localparam int unsigned CTL_RESUME_BIT = 2;
    localparam int unsigned CTL_BANK_POINTER_RESET_BIT = 1;
    localparam int unsigned CTL_ENABLE_BIT = 0;

    // main interrupt registers
    localparam int unsigned IE_ERROR_BIT   = 1;
    localparam int unsigned IF_TOKDONE_BIT = 3;

    // status layout and transaction fifo
    localparam int unsigned STAT_INFO_LSB  = 2;
    localparam int unsigned FIFO_DEPTH     = 4;

    // reset values
    localparam logic [7:0] ERR_FLAGS_RESET  = 8'h00;
    localparam logic [7:0] ERR_ENABLE_RESET = 8'h00;
    localparam logic [5:0] CONTROL_RESET    = 6'h00;

    // one finished transfer as reported in the status window
    typedef struct packed {
        logic [3:0] endpoint;
        logic       tx;
        logic       odd;
    } usbec_xfer_t;

    // avalon-mm request from the master
    typedef struct packed {
        logic [2:0]  address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } usbec_req_t;

endpackage : usbec_pkg

`default_nettype wire

// >>> core/usbec_core.sv
// usbec_core: error-interrupt gating, transaction status fifo window and
// usb control register behind an avalon-mm slave with waitrequest.
// assumes the protocol engine delivers one-cycle event pulses on mclk.
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module usbec_core (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_b,
    // avalon-mm slave
    input  wire usbec_pkg::usbec_req_t av_req,
    output logic                    av_waitrequest,
    output logic [31:0]             av_readdata,
    // protocol engine events
    input  wire logic [7:0]         err_event,
    input  wire logic               setup_seen,
    input  wire logic               token_active,
    input  wire logic               xfer_valid,
    input  wire usbec_pkg::usbec_xfer_t xfer_info,
    output logic                    xfer_ready,
    // live line state
    input  wire logic               line_j_live,
    input  wire logic               line_se_zero_live,
    // control outputs
    output logic                    usb_irq_request,
    output logic                    packet_disable,
    output logic                    bus_reset_drive,
    output logic                    host_enable,
    output logic                    host_logic_reset,
    output logic                    resume_drive,
    output logic                    ls_eop_append,
    output logic                    bank_pointer_reset,
    output logic                    module_enable
);

    ////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, so read data is registered

    logic        ack_q;
    logic        req_on;
    logic        acc;
    logic        wr_acc;
    logic [31:0] rdata_q;

    function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
        hit = (a == idx);
    endfunction : hit

    assign req_on         = av_req.read | av_req.write;
    assign av_waitrequest = req_on & ~ack_q;
    assign acc            = req_on & ack_q;
    // only lane 0 carries implemented bits
    assign wr_acc         = acc & av_req.write & av_req.byteenable[0];
    assign av_readdata    = rdata_q;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req_on & ~ack_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // error flags and enables

    logic [7:0] err_flags_q;
    logic [7:0] err_en_q;
    logic       master_en_q;
    logic [7:0] err_clr;
    logic       wr_flags;
    logic       wr_en;
    logic       wr_ie;

    assign wr_flags = wr_acc & hit(av_req.address, usbec_pkg::IDX_ERR_FLAGS);
    assign wr_en    = wr_acc & hit(av_req.address, usbec_pkg::IDX_ERR_ENABLE);
    assign wr_ie    = wr_acc & hit(av_req.address, usbec_pkg::IDX_IRQ_ENABLE);
    assign err_clr  = wr_flags ? av_req.writedata[7:0] : 8'h00;

    // bit 1 is crc5 in device role and eof in host role; the engine
    // reports whichever applies on err_event[1], so one gate serves both
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            err_en_q <= usbec_pkg::ERR_ENABLE_RESET;
        end else if (wr_en) begin
            err_en_q <= av_req.writedata[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            master_en_q <= 1'b0;
        end else if (wr_ie) begin
            master_en_q <= av_req.writedata[usbec_pkg::IE_ERROR_BIT];
        end
    end

    // a new event beats a write-one clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            err_flags_q <= usbec_pkg::ERR_FLAGS_RESET;
        end else begin
            err_flags_q <= (err_flags_q & ~err_clr) | err_event;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            usb_irq_request <= 1'b0;
        end else begin
            usb_irq_request <= master_en_q & (|(err_flags_q & err_en_q));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transaction fifo behind the status window

    usbec_pkg::usbec_xfer_t fifo_mem [usbec_pkg::FIFO_DEPTH];
    logic [1:0] wr_ptr_q;
    logic [1:0] rd_ptr_q;
    logic [2:0] count_q;
    logic       push;
    logic       pop;
    logic       tok_done;

    assign tok_done   = (count_q != 3'h0);
    // full fifo stalls the engine rather than dropping a transfer
    assign xfer_ready = (count_q != 3'(usbec_pkg::FIFO_DEPTH));
    assign push       = xfer_valid & xfer_ready;
    assign pop        = wr_acc & hit(av_req.address, usbec_pkg::IDX_IRQ_FLAGS)
                        & av_req.writedata[usbec_pkg::IF_TOKDONE_BIT] & tok_done;

    // entries carry no reset: contents are undefined until written
    always_ff @(posedge mclk) begin
        if (push) begin
            fifo_mem[wr_ptr_q] <= xfer_info;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wr_ptr_q <= 2'h0;
            rd_ptr_q <= 2'h0;
            count_q  <= 3'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 2'h1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 2'h1;
            end
            if (push & ~pop) begin
                count_q <= count_q + 3'h1;
            end else if (pop & ~push) begin
                count_q <= count_q - 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control register

    logic [5:0] ctl_q;
    logic       wr_ctl;
    logic [7:0] wd;
    logic       host_rst_q;
    logic       ls_eop_q;

    assign wr_ctl = wr_acc & hit(av_req.address, usbec_pkg::IDX_CONTROL);
    assign wd     = av_req.writedata[7:0];

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctl_q <= usbec_pkg::CONTROL_RESET;
        end else begin
            if (wr_ctl) begin
                ctl_q <= wd[5:0];
            end
            // with host enable clear, a setup token sets the disable even against a clearing write
            if (setup_seen & ~ctl_q[usbec_pkg::CTL_HOST_ENABLE_BIT]) begin
                ctl_q[usbec_pkg::CTL_PACKET_DISABLE_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            host_rst_q <= 1'b0;
            ls_eop_q   <= 1'b0;
        end else begin
            host_rst_q <= wr_ctl & (wd[usbec_pkg::CTL_HOST_ENABLE_BIT]
                          != ctl_q[usbec_pkg::CTL_HOST_ENABLE_BIT]);
            ls_eop_q   <= wr_ctl & ctl_q[usbec_pkg::CTL_HOST_ENABLE_BIT]
                          & ctl_q[usbec_pkg::CTL_RESUME_BIT]
                          & ~wd[usbec_pkg::CTL_RESUME_BIT];
        end
    end

    assign packet_disable     = ctl_q[usbec_pkg::CTL_PACKET_DISABLE_BIT] & ~ctl_q[usbec_pkg::CTL_HOST_ENABLE_BIT];
    assign bus_reset_drive    = ctl_q[usbec_pkg::CTL_BUSRST_BIT];
    assign host_enable        = ctl_q[usbec_pkg::CTL_HOST_ENABLE_BIT];
    assign resume_drive       = ctl_q[usbec_pkg::CTL_RESUME_BIT];
    assign bank_pointer_reset = ctl_q[usbec_pkg::CTL_BANK_POINTER_RESET_BIT];
    assign module_enable      = ctl_q[usbec_pkg::CTL_ENABLE_BIT];
    assign host_logic_reset   = host_rst_q;
    assign ls_eop_append      = ls_eop_q;

    ////////////////////////////////////////////////////////////////////
    // read mux, captured on the wait-state edge

    logic [7:0] ctl_rd;

    always_comb begin
        ctl_rd = {2'b00, ctl_q};
        ctl_rd[usbec_pkg::CTL_J_BIT]   = line_j_live;
        ctl_rd[usbec_pkg::CTL_SE0_BIT] = line_se_zero_live;
        if (ctl_q[usbec_pkg::CTL_HOST_ENABLE_BIT]) begin
            ctl_rd[usbec_pkg::CTL_PACKET_DISABLE_BIT] = token_active;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rdata_q <= 32'h0000_0000;
        end else if (av_req.read & ~ack_q) begin
            if (hit(av_req.address, usbec_pkg::IDX_ERR_FLAGS)) begin
                rdata_q <= {24'h00_0000, err_flags_q};
            end else if (hit(av_req.address, usbec_pkg::IDX_ERR_ENABLE)) begin
                rdata_q <= {24'h00_0000, err_en_q};
            end else if (hit(av_req.address, usbec_pkg::IDX_STATUS)) begin
                rdata_q <= {24'h00_0000, fifo_mem[rd_ptr_q], 2'b00};
            end else if (hit(av_req.address, usbec_pkg::IDX_CONTROL)) begin
                rdata_q <= {24'h00_0000, ctl_rd};
            end else if (hit(av_req.address, usbec_pkg::IDX_IRQ_ENABLE)) begin
                rdata_q <= 32'(master_en_q) << usbec_pkg::IE_ERROR_BIT;
            end else if (hit(av_req.address, usbec_pkg::IDX_IRQ_FLAGS)) begin
                rdata_q <= 32'(tok_done) << usbec_pkg::IF_TOKDONE_BIT;
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    property p_irq_gate;
        (master_en_q && |(err_flags_q & err_en_q)) |=> usb_irq_request;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not raised");

    property p_irq_master;
        !master_en_q |=> !usb_irq_request;
    endproperty
    a_irq_master: assert property (p_irq_master) else $error("irq without master");

    property p_flag_set;
        err_event[0] |=> err_flags_q[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag lost");

    property p_flag_hold;
        (!err_event[7] && !err_clr[7]) |=> $stable(err_flags_q[7]);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag moved");

    property p_setup;
        (setup_seen && !host_enable) |=> packet_disable;
    endproperty
    a_setup: assert property (p_setup) else $error("setup ignored");

    property p_host_toggle;
        $changed(host_enable) |-> host_logic_reset;
    endproperty
    a_host_toggle: assert property (p_host_toggle) else $error("no host reset");

    property p_ls_eop;
        ($fell(resume_drive) && host_enable) |-> ls_eop_append;
    endproperty
    a_ls_eop: assert property (p_ls_eop) else $error("no eop");

    property p_pop;
        (pop && !push) |=> (count_q == $past(count_q) - 3'h1);
    endproperty
    a_pop: assert property (p_pop) else $error("pop lost");

    property p_upper_zero;
        (av_req.read && !av_waitrequest) |-> (av_readdata[31:8] == 24'h00_0000);
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

endmodule : usbec_core

`default_nettype wire

// >>> verification/usbec_engine_model.sv
// usbec_engine_model: stand-in for the usb protocol engine and bus lines.
// assumes the bench calls its tasks between edges; each starts on a rising edge.
`timescale 1ns/10ps
`default_nettype none
module usbec_engine_model (
    // clock
    input  wire logic                  mclk,
    // engine events toward the core
    output var logic [7:0]             err_event,
    output var logic                   setup_seen,
    output var logic                   token_active,
    output var logic                   xfer_valid,
    output var usbec_pkg::usbec_xfer_t xfer_info,
    input  wire logic                  xfer_ready,
    // live line state
    output var logic                   line_j_live,
    output var logic                   line_se_zero_live
);
    initial begin
        err_event         = 8'h00;
        setup_seen        = 1'b0;
        token_active      = 1'b0;
        xfer_valid        = 1'b0;
        xfer_info         = '0;
        line_j_live       = 1'b1;
        line_se_zero_live = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic err(input logic [7:0] m);
        @(posedge mclk);
        err_event <= m;
        @(posedge mclk);
        err_event <= 8'h00;
    endtask : err
    task automatic setup();
        @(posedge mclk);
        setup_seen <= 1'b1;
        @(posedge mclk);
        setup_seen <= 1'b0;
    endtask : setup
    task automatic busy(input logic b);
        @(posedge mclk);
        token_active <= b;
    endtask : busy
    task automatic lines(input logic j, input logic s);
        @(posedge mclk);
        line_j_live       <= j;
        line_se_zero_live <= s;
    endtask : lines
    // offer held until ready is seen high at a rising edge, then dropped
    task automatic push(input usbec_pkg::usbec_xfer_t x);
        @(posedge mclk);
        xfer_valid <= 1'b1;
        xfer_info  <= x;
        do @(posedge mclk); while (xfer_ready !== 1'b1);
        xfer_valid <= 1'b0;
        xfer_info  <= ~x;
    endtask : push
endmodule : usbec_engine_model
`default_nettype wire

// >>> verification/testbench.sv
// testbench: register and event checks of the usb error/status/control core.
// assumes usbec_engine_model plays the protocol engine and the bus lines.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    logic                   mclk;
    logic                   rst_b;
    usbec_pkg::usbec_req_t  av_req;
    logic                   av_waitrequest;
    logic [31:0]            av_readdata;
    logic [7:0]             err_event;
    logic                   setup_seen, token_active, xfer_valid, xfer_ready;
    usbec_pkg::usbec_xfer_t xfer_info;
    logic                   line_j_live, line_se_zero_live, usb_irq_request, packet_disable;
    logic                   bus_reset_drive, host_enable, host_logic_reset, resume_drive;
    logic                   ls_eop_append, bank_pointer_reset, module_enable;
    int                     err_total, num_checks, cyc, n_hrst, n_eop;
    logic [31:0]            q;

    usbec_core i_dut (.mclk, .rst_b, .av_req, .av_waitrequest, .av_readdata, .err_event, .setup_seen,
        .token_active, .xfer_valid, .xfer_info, .xfer_ready, .line_j_live, .line_se_zero_live,
        .usb_irq_request, .packet_disable, .bus_reset_drive, .host_enable, .host_logic_reset,
        .resume_drive, .ls_eop_append, .bank_pointer_reset, .module_enable);
    usbec_engine_model i_eng (.mclk, .err_event, .setup_seen, .token_active, .xfer_valid,
        .xfer_info, .xfer_ready, .line_j_live, .line_se_zero_live);

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // pulses counted, so their exact cycle need not be guessed here
    always @(posedge mclk) begin
        cyc++;
        n_hrst += (host_logic_reset === 1'b1);
        n_eop  += (ls_eop_append === 1'b1);
        if (cyc == 5000) begin
            err_total++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    // one idle edge before each request keeps release and raise apart;
    // waitrequest and read data are taken at the rising edge of acceptance
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        @(posedge mclk);
        av_req <= '{address: a, read: !w, write: w, byteenable: 4'hf, writedata: d};
        do @(posedge mclk); while (av_waitrequest !== 1'b0);
        q = av_readdata;
        av_req <= '0;
    endtask : bus
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus(0, 3'h1, '0);
        `CHK(q, 32'h0000_0000)
        bus(0, 3'h3, '0);
        `CHK(q, 32'h0000_0080)
        `CHK({bus_reset_drive, host_enable, resume_drive, bank_pointer_reset, module_enable}, 5'h00)
        bus(0, 3'h7, '0);
        `CHK(q, 32'h0000_0000)
    endtask : t_reset
    task automatic t_enable();
        bus(1, 3'h1, 32'hffff_ffff);
        bus(0, 3'h1, '0);
        `CHK(q, 32'h0000_00ff)
        bus(1, 3'h1, 32'h0000_00a5);
        bus(0, 3'h1, '0);
        `CHK(q, 32'h0000_00a5)
    endtask : t_enable
    // each bit alone, both roles: others must not leak into the request
    task automatic t_gating();
        bus(1, 3'h4, 32'h0000_0002);
        for (int r = 0; r < 2; r++) begin
            bus(1, 3'h3, 32'(r * 8));
            for (int n = 0; n < 8; n++) begin
                bus(1, 3'h1, 32'h0000_0001 << n);
                i_eng.err(~(8'h01 << n));
                repeat (2) @(negedge mclk);
                `CHK(usb_irq_request, 1'b0)
                bus(0, 3'h0, '0);
                `CHK(q, {24'h00_0000, ~(8'h01 << n)})
                i_eng.err(8'h01 << n);
                repeat (2) @(negedge mclk);
                `CHK(usb_irq_request, 1'b1)
                bus(1, 3'h0, 32'h0000_00ff);
                bus(0, 3'h0, '0);
                `CHK(q, 32'h0000_0000)
                `CHK({r[0], n[2:0], usb_irq_request}, {r[0], n[2:0], 1'b0})
            end
        end
        bus(1, 3'h3, '0);
        bus(1, 3'h1, 32'h0000_00ff);
        bus(1, 3'h4, '0);
        i_eng.err(8'h04);
        repeat (2) @(negedge mclk);
        `CHK(usb_irq_request, 1'b0)
        bus(1, 3'h0, 32'h0000_00ff);
        `CHK(n_hrst, 2)
    endtask : t_gating
    task automatic t_fifo();
        usbec_pkg::usbec_xfer_t t [4] = '{'{4'hf, 1'b1, 1'b0}, '{4'h0, 1'b0, 1'b1},
                                          '{4'h5, 1'b1, 1'b1}, '{4'ha, 1'b0, 1'b0}};
        foreach (t[i]) i_eng.push(t[i]);
        @(negedge mclk);
        `CHK(xfer_ready, 1'b0)
        foreach (t[i]) begin
            bus(0, 3'h5, '0);
            `CHK(q, 32'h0000_0008)
            bus(0, 3'h2, '0);
            `CHK(q, {24'h00_0000, t[i], 2'b00})
            bus(1, 3'h5, 32'h0000_0008);
        end
        bus(0, 3'h5, '0);
        `CHK(q, 32'h0000_0000)
    endtask : t_fifo
    task automatic t_control();
        bus(1, 3'h3, 32'h0000_0037);
        @(negedge mclk);
        `CHK({packet_disable, bus_reset_drive, host_enable, resume_drive, bank_pointer_reset, module_enable}, 6'h37)
        i_eng.lines(1'b0, 1'b1);
        bus(0, 3'h3, '0);
        `CHK(q, 32'h0000_0077)
        bus(1, 3'h3, '0);
        i_eng.setup();
        @(negedge mclk);
        `CHK(packet_disable, 1'b1)
        bus(1, 3'h3, 32'h0000_000c);
        i_eng.busy(1'b1);
        bus(0, 3'h3, '0);
        `CHK(q, 32'h0000_006c)
        i_eng.busy(1'b0);
        bus(0, 3'h3, '0);
        `CHK(q, 32'h0000_004c)
        // resume held only a few cycles: the wake-up time would blow the run budget
        bus(1, 3'h3, 32'h0000_0008);
        // pulse lands after the write edge and is counted one edge later
        repeat (2) @(negedge mclk);
        `CHK(n_eop, 1)
        `CHK(n_hrst, 3)
    endtask : t_control
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b  = 1'b0;
        av_req = '0;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_enable();
        t_gating();
        t_fifo();
        t_control();
        final_report();
    end
endmodule : testbench
`default_nettype wire
